// File: sim/fsp_host.sv
// Serial host model that drives the status bank's pins in SPI mode 0.
// Assumes clk runs at 100 MHz; each sck phase lasts three clk cycles.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_map.svh"
module fsp_host (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  // Idle bus: deselected, clock low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // One sck phase, changed just after a clk edge
  task automatic ph(input logic lvl);
    repeat (3) @(posedge clk);
    #1 sck = lvl;
  endtask : ph
  // Frame of n whole bytes of d, MSB first, then an optional read byte
  task automatic frame(input logic [31:0] d, input int n, input bit rd,
                       output logic [7:0] r);
    int i;
    r = 8'h00;
    @(posedge clk);
    #1 cs_n = 1'b0;
    for (i = 8 * n - 1; i >= 0; i--) begin
      si = d[i];
      ph(1'b1);
      ph(1'b0);
    end
    for (i = 7; rd && i >= 0; i--) begin
      si = ~si; // Line is not read here, so keep it moving
      repeat (3) @(posedge clk);
      #1 r[i] = so_oe ? so : 1'bx;
      sck = 1'b1;
      ph(1'b0);
    end
    repeat (3) @(posedge clk);
    #1 cs_n = 1'b1;
    repeat (4) @(posedge clk);
    // Return off the edge so that callers change pins after it
    #1;
  endtask : frame
  task automatic poll(output bit ok);
    logic [7:0] r;
    ok = 1'b0;
    for (int k = 0; k < 40 && !ok; k++) begin
      frame({24'h0, `FSP_OP_RDSL}, 1, 1'b1, r);
      ok = (r[0] === 1'b0);
    end
  endtask : poll
endmodule : fsp_host
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the flash status/protection bank.
// Assumes the bank and the host model fsp_host are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_map.svh"
module testbench;
  logic clk, rst_n, nv_rst_n, wp_n, sck, cs_n, si, so, so_oe;
  logic busy, quad_mode;
  logic [2:0] otp_lock;
  logic [7:0] r;
  int mismatches = 0;
  int tests_run = 0;
  // Clock of 10 ns
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  fsp_host host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
    .so_oe(so_oe));
  fsp_status_regs #(.WR_CYC(300), .PROG_CYC(300), .SE_CYC(400),
    .BE_CYC(400), .CE_CYC(400)) uut (.clk(clk), .rst_n(rst_n),
    .nv_rst_n(nv_rst_n), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe(so_oe), .busy(busy), .quad_mode(quad_mode),
    .otp_lock(otp_lock));
  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [31:0] d, input int n);
    logic [7:0] x;
    host.frame(d, n, 1'b0, x);
  endtask : cmd
  task automatic rd(input logic [7:0] op);
    host.frame({24'h0, op}, 1, 1'b1, r);
  endtask : rd
  task automatic ready();
    bit ok;
    host.poll(ok);
    if (!ok) begin
      mismatches++;
      $display("unexpected at %0t: busy never cleared", $time);
      results();
    end
  endtask : ready
  // Enable, write both status bytes, wait until idle
  task automatic wrsr(input logic [7:0] l, input logic [7:0] h);
    cmd({24'h0, `FSP_OP_WREN}, 1);
    cmd({8'h0, `FSP_OP_WRSR, l, h}, 3);
    ready();
  endtask : wrsr
  task automatic pwr();
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
  endtask : pwr
  // Sector erase at a, accepted or refused by the protection map
  task automatic er(input logic [7:0] l, input logic [7:0] h,
                    input logic [23:0] a, input logic ok);
    wrsr(l, h);
    cmd({24'h0, `FSP_OP_WREN}, 1);
    cmd({`FSP_OP_SE, a}, 4);
    chk({7'h0, busy}, {7'h0, ok});
    if (ok) ready();
    rd(`FSP_OP_RDSL);
    chk(r, l | (ok ? 8'h00 : 8'h02));
    cmd({24'h0, `FSP_OP_WRDI}, 1);
  endtask : er
  task automatic t_reset();
    rd(`FSP_OP_RDSL);
    chk(r, 8'h00);
    rd(`FSP_OP_RDSH);
    chk(r, 8'h00);
    chk({7'h0, busy}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wel();
    cmd({24'h0, `FSP_OP_WREN}, 1);
    rd(`FSP_OP_RDSL);
    chk(r, 8'h02);
    cmd({24'h0, `FSP_OP_WRDI}, 1);
    rd(`FSP_OP_RDSL);
    chk(r, 8'h00);
    $display("test wel done");
  endtask : t_wel
  task automatic t_busy();
    cmd({24'h0, `FSP_OP_WREN}, 1);
    cmd({8'h0, `FSP_OP_WRSR, 8'h0c, 8'h00}, 3);
    chk({7'h0, busy}, 8'h01);
    cmd({24'h0, `FSP_OP_WREN}, 1);
    rd(`FSP_OP_RDSL);
    chk(r, 8'h0d);
    ready();
    rd(`FSP_OP_RDSL);
    chk(r, 8'h0c);
    wrsr(8'h00, 8'h00);
    $display("test busy done");
  endtask : t_busy
  task automatic t_protect();
    er(8'h04, 8'h00, 24'h0f0000, 1'b0);
    er(8'h04, 8'h00, 24'h0e0000, 1'b1);
    er(8'h14, 8'h00, 24'h000000, 1'b0);
    er(8'h44, 8'h00, 24'h0ff000, 1'b0);
    er(8'h44, 8'h00, 24'h0fe000, 1'b1);
    er(8'h64, 8'h00, 24'h000000, 1'b0);
    er(8'h64, 8'h00, 24'h001000, 1'b1);
    er(8'h44, 8'h40, 24'h0fe000, 1'b0);
    er(8'h44, 8'h40, 24'h0ff000, 1'b1);
    wrsr(8'h00, 8'h00);
    $display("test protect done");
  endtask : t_protect
  task automatic t_suspend();
    cmd({24'h0, `FSP_OP_WREN}, 1);
    cmd({`FSP_OP_SE, 24'h000000}, 4);
    cmd({24'h0, `FSP_OP_SUSP}, 1);
    rd(`FSP_OP_RDSH);
    chk(r, 8'h80);
    cmd({24'h0, `FSP_OP_RES}, 1);
    rd(`FSP_OP_RDSH);
    chk(r, 8'h00);
    ready();
    $display("test suspend done");
  endtask : t_suspend
  task automatic t_lock();
    wp_n = 1'b0;
    wrsr(8'h00, 8'h08);
    chk({5'h0, otp_lock}, 8'h01);
    wrsr(8'h00, 8'h00);
    chk({5'h0, otp_lock}, 8'h01);
    wp_n = 1'b1;
    wrsr(8'h80, 8'h08);
    wp_n = 1'b0;
    wrsr(8'h84, 8'h08);
    rd(`FSP_OP_RDSL);
    chk(r, 8'h82);
    wp_n = 1'b1;
    wrsr(8'h80, 8'h0a);
    chk({7'h0, quad_mode}, 8'h01);
    wp_n = 1'b0;
    wrsr(8'h84, 8'h0a);
    rd(`FSP_OP_RDSL);
    chk(r, 8'h84);
    wrsr(8'h00, 8'h09);
    wrsr(8'h04, 8'h08);
    rd(`FSP_OP_RDSL);
    chk(r, 8'h02);
    pwr();
    rd(`FSP_OP_RDSH);
    chk(r, 8'h08);
    wrsr(8'h80, 8'h09);
    pwr();
    wrsr(8'h00, 8'h00);
    rd(`FSP_OP_RDSH);
    chk(r, 8'h09);
    rd(`FSP_OP_RDSL);
    chk(r, 8'h82);
    $display("test lock done");
  endtask : t_lock
  // Main sequence: reset for 20 cycles, then each scenario
  initial begin
    rst_n = 1'b0;
    nv_rst_n = 1'b0;
    wp_n = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    nv_rst_n = 1'b1;
    t_reset();
    t_wel();
    t_busy();
    t_protect();
    t_suspend();
    t_lock();
    results();
  end
endmodule : testbench
`default_nettype wire

// File: src/fsp_map.svh
// Offsets, field positions, opcodes and factory values of the
// flash status/protection bank. Included by the bank and decoder.
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// Serial instruction codes
`define FSP_OP_WREN 8'h06
`define FSP_OP_WRDI 8'h04
`define FSP_OP_RDSL 8'h05
`define FSP_OP_RDSH 8'h35
`define FSP_OP_WRSR 8'h01
`define FSP_OP_PP 8'h02
`define FSP_OP_QPP 8'h32
`define FSP_OP_SE 8'h20
`define FSP_OP_BE32 8'h52
`define FSP_OP_BE64 8'hd8
`define FSP_OP_CE1 8'hc7
`define FSP_OP_CE2 8'h60
`define FSP_OP_SUSP 8'h75
`define FSP_OP_RES 8'h7a
`define FSP_OP_SCER 8'h44
`define FSP_OP_SCPR 8'h42

// Bit positions in status_low
`define FSP_SL_BUSY 0
`define FSP_SL_WEL 1
`define FSP_SL_BP 2
`define FSP_SL_TB 5
`define FSP_SL_SEC 6
`define FSP_SL_LMLO 7
// Bit positions in status_high
`define FSP_SH_LMHI 0
`define FSP_SH_QE 1
`define FSP_SH_LB 3
`define FSP_SH_CMP 6
`define FSP_SH_SUS 7

// Factory value of every stored bit
`define FSP_FACTORY 1'b0
// Array geometry
`define FSP_TOP 20'hfffff
`define FSP_SPAN 21'h100000
`define FSP_BLK64 21'h010000
`define FSP_SEC4 21'h001000
`define FSP_BLK32 20'h07fff
`define FSP_PAGE 20'h000ff
`define FSP_SEC4M 20'h00fff
`define FSP_BLK64M 20'h0ffff

`endif

// File: src/fsp_pkg.sv
// Types shared by the flash status/protection bank.
// Assumes fsp_map.svh carries the numeric constants.
package fsp_pkg;
  // Operation state of the bank
  typedef enum logic [1:0] {
    FSP_IDLE = 2'b00,
    FSP_RUN = 2'b01,
    FSP_SUSP = 2'b10
  } fsp_state_t;
endpackage : fsp_pkg

// File: src/fsp_prot_decode.sv
// Protected address range decoder for the 1 MB array.
// Assumes stable status bits from the bank; no clock.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_map.svh"
module fsp_prot_decode (
  fsp_prot_if.dec p
);
  logic all_raw;
  logic none_raw;
  logic [1:0] shf;
  logic [20:0] len;
  logic [19:0] rlo;
  logic [19:0] rhi;

  // Size, anchor and complement of the protected region
  always_comb begin
    none_raw = (p.bp == 3'h0);
    all_raw = (p.bp[2] & p.bp[1]) | (!p.sec & p.bp == 3'h5);
    shf = p.bp[2] ? 2'h3 : 2'(p.bp[1:0] - 2'h1);
    len = (p.sec ? `FSP_SEC4 : `FSP_BLK64) << shf;
    if (all_raw) begin
      rlo = 20'h00000;
      rhi = `FSP_TOP;
    end else if (p.tb) begin
      rlo = 20'h00000;
      rhi = 20'(len - 21'h1);
    end else begin
      rlo = 20'(`FSP_SPAN - len);
      rhi = `FSP_TOP;
    end
    p.none = none_raw;
    p.lo = rlo;
    p.hi = rhi;
    if (p.cmp) begin
      p.none = all_raw;
      if (none_raw) begin
        p.lo = 20'h00000;
        p.hi = `FSP_TOP;
      end else if (rlo == 20'h00000) begin
        p.lo = 20'(rhi + 20'h1);
        p.hi = `FSP_TOP;
      end else begin
        p.lo = 20'h00000;
        p.hi = 20'(rlo - 20'h1);
      end
    end
  end
endmodule : fsp_prot_decode
`default_nettype wire

// File: src/fsp_prot_if.sv
// Protection bits out to the decoder and protected range back.
// Assumes a purely combinational decoder on the far side.
`timescale 1ns/10ps
`default_nettype none
interface fsp_prot_if;
  logic [2:0] bp;
  logic tb;
  logic sec;
  logic cmp;
  logic none;
  logic [19:0] lo;
  logic [19:0] hi;
  modport ctl(output bp, tb, sec, cmp, input none, lo, hi);
  modport dec(input bp, tb, sec, cmp, output none, lo, hi);
endinterface : fsp_prot_if
`default_nettype wire

// File: src/fsp_status_regs.sv
// Status and protection register bank of a serial flash,
// reached by status instructions on the serial pins.
// Assumes pins synchronous to clk and sck slower than clk/2.
`timescale 1ns/10ps
`default_nettype none
`include "fsp_map.svh"
module fsp_status_regs #(
  parameter int WR_CYC = 1500,
  parameter int PROG_CYC = 700,
  parameter int SE_CYC = 6000,
  parameter int BE_CYC = 20000,
  parameter int CE_CYC = 90000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic nv_rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic busy,
  output logic quad_mode,
  output logic [2:0] otp_lock
);
  fsp_pkg::fsp_state_t state_reg;
  logic busy_reg;
  logic sus_reg;
  logic wel_reg;
  logic [31:0] tmr_reg;
  logic run_sr_reg;
  logic sck_reg;
  logic cs_reg;
  logic [2:0] bit_reg;
  logic [2:0] byte_reg;
  logic [6:0] sh_reg;
  logic [7:0] op_reg;
  logic [19:0] addr_reg;
  logic [7:0] d1_reg;
  logic [7:0] d2_reg;
  logic so_reg;
  logic so_oe_reg;
  logic [2:0] bp_reg;
  logic tb_reg;
  logic sec_reg;
  logic [1:0] lm_reg;
  logic qe_reg;
  logic [2:0] lb_reg;
  logic cmp_reg;
  logic rise;
  logic fall;
  logic cmd_end;
  logic [7:0] nb;
  logic [7:0] sl;
  logic [7:0] sh;
  logic wp_eff;
  logic lock_ok;
  logic st_go;
  logic pe_go;
  logic sc_go;
  logic start;
  logic hit;
  logic [19:0] t_lo;
  logic [19:0] t_hi;
  logic idle;
  fsp_prot_if pif ();

  // Byte offset mask of the region an instruction touches
  function automatic logic [19:0] span_mask(input logic [7:0] op);
    case (op)
      `FSP_OP_SE: span_mask = `FSP_SEC4M;
      `FSP_OP_BE32: span_mask = `FSP_BLK32;
      `FSP_OP_BE64: span_mask = `FSP_BLK64M;
      `FSP_OP_CE1, `FSP_OP_CE2: span_mask = `FSP_TOP;
      default: span_mask = `FSP_PAGE;
    endcase
  endfunction : span_mask

  // Busy time for an accepted instruction
  function automatic logic [31:0] cyc_of(input logic [7:0] op);
    case (op)
      `FSP_OP_WRSR: cyc_of = 32'(WR_CYC);
      `FSP_OP_SE, `FSP_OP_SCER: cyc_of = 32'(SE_CYC);
      `FSP_OP_BE32, `FSP_OP_BE64: cyc_of = 32'(BE_CYC);
      `FSP_OP_CE1, `FSP_OP_CE2: cyc_of = 32'(CE_CYC);
      default: cyc_of = 32'(PROG_CYC);
    endcase
  endfunction : cyc_of

  // Decoder of the protected range
  fsp_prot_decode u_dec (
    .p(pif.dec)
  );

  assign pif.bp = bp_reg;
  assign pif.tb = tb_reg;
  assign pif.sec = sec_reg;
  assign pif.cmp = cmp_reg;

  // Pin edges and byte framing
  assign rise = !cs_n && sck && !sck_reg;
  assign fall = !cs_n && !sck && sck_reg;
  assign cmd_end = cs_n && !cs_reg && byte_reg != 3'h0 && bit_reg == 3'h0;
  assign nb = {sh_reg, si};
  assign idle = (state_reg == fsp_pkg::FSP_IDLE);

  // Register images seen by status reads
  assign sl = {lm_reg[0], sec_reg, tb_reg, bp_reg, wel_reg, busy_reg};
  assign sh = {sus_reg, cmp_reg, lb_reg, 1'b0, qe_reg, lm_reg[1]};

  assign wp_eff = wp_n | qe_reg;

  assign lock_ok = (lm_reg == 2'b00) || (lm_reg == 2'b01 && wp_eff);

  // Target range of an array instruction
  assign t_lo = addr_reg & ~span_mask(op_reg);
  assign t_hi = addr_reg | span_mask(op_reg);

  assign hit = !pif.none && !(t_hi < pif.lo || t_lo > pif.hi);

  // Accepted instructions, taken only when idle
  always_comb begin
    st_go = op_reg == `FSP_OP_WRSR && wel_reg && lock_ok;
    pe_go = 1'b0;
    sc_go = 1'b0;
    case (op_reg)
      `FSP_OP_PP, `FSP_OP_QPP:
        pe_go = wel_reg && !hit && byte_reg >= 3'h5;
      `FSP_OP_SE, `FSP_OP_BE32, `FSP_OP_BE64:
        pe_go = wel_reg && !hit && byte_reg == 3'h4;
      `FSP_OP_CE1, `FSP_OP_CE2:
        pe_go = wel_reg && pif.none && byte_reg == 3'h1;
      `FSP_OP_SCER:
        sc_go = wel_reg && byte_reg == 3'h4;
      `FSP_OP_SCPR:
        sc_go = wel_reg && byte_reg >= 3'h5;
      default: begin
      end
    endcase
    if (addr_reg[13:12] == 2'h0 || lb_reg[addr_reg[13:12] - 2'h1])
      sc_go = 1'b0;
    if (byte_reg < 3'h2)
      st_go = 1'b0;
  end

  // busy or suspended refuses new work
  assign start = cmd_end && idle && (st_go || pe_go || sc_go);

  // Edge history of the serial pins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_reg <= 1'b0;
      cs_reg <= 1'b1;
    end else begin
      sck_reg <= sck;
      cs_reg <= cs_n;
    end
  end

  // Bit and byte counters, MSB-first shifter
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) begin
      bit_reg <= 3'h0;
      byte_reg <= 3'h0;
      sh_reg <= 7'h00;
    end else if (rise) begin
      bit_reg <= 3'(bit_reg + 3'h1);
      sh_reg <= nb[6:0];
      if (bit_reg == 3'h7 && byte_reg != 3'h7)
        byte_reg <= 3'(byte_reg + 3'h1);
    end
  end

  // Opcode, address and status data capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_reg <= 8'h00;
      addr_reg <= 20'h00000;
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
    end else if (rise && bit_reg == 3'h7) begin
      case (byte_reg)
        3'h0: op_reg <= nb;
        3'h1: begin
          addr_reg[19:16] <= nb[3:0];
          d1_reg <= nb;
        end
        3'h2: begin
          addr_reg[15:8] <= nb;
          d2_reg <= nb;
        end
        3'h3: addr_reg[7:0] <= nb;
        default: begin
        end
      endcase
    end
  end

  // Status read shifter, driven on falling sck
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else if (fall && byte_reg != 3'h0) begin
      if (op_reg == `FSP_OP_RDSL) begin
        so_oe_reg <= 1'b1;
        so_reg <= sl[3'h7 - bit_reg];
      end else if (op_reg == `FSP_OP_RDSH) begin
        so_oe_reg <= 1'b1;
        so_reg <= sh[3'h7 - bit_reg];
      end
    end
  end

  // Operation state, busy timer and suspend flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= fsp_pkg::FSP_IDLE;
      busy_reg <= 1'b0;
      sus_reg <= 1'b0;
      tmr_reg <= 32'h0;
      run_sr_reg <= 1'b0;
    end else begin
      case (state_reg)
        fsp_pkg::FSP_IDLE: begin
          if (start) begin
            state_reg <= fsp_pkg::FSP_RUN;
            busy_reg <= 1'b1;
            tmr_reg <= cyc_of(op_reg);
            run_sr_reg <= st_go || sc_go;
          end
        end
        fsp_pkg::FSP_RUN: begin
          if (cmd_end && op_reg == `FSP_OP_SUSP && !run_sr_reg) begin
            state_reg <= fsp_pkg::FSP_SUSP;
            busy_reg <= 1'b0;
            sus_reg <= 1'b1;
          end else if (tmr_reg <= 32'h1) begin
            state_reg <= fsp_pkg::FSP_IDLE;
            busy_reg <= 1'b0;
          end else begin
            tmr_reg <= tmr_reg - 32'h1;
          end
        end
        fsp_pkg::FSP_SUSP: begin
          if (cmd_end && op_reg == `FSP_OP_RES) begin
            state_reg <= fsp_pkg::FSP_RUN;
            busy_reg <= 1'b1;
            sus_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= fsp_pkg::FSP_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // Write enable latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wel_reg <= 1'b0;
    end else if (cmd_end && !busy_reg) begin
      if (op_reg == `FSP_OP_WREN)
        wel_reg <= 1'b1;
      // cleared by disable or accepted write
      else if (op_reg == `FSP_OP_WRDI || start)
        wel_reg <= 1'b0;
    end
  end

  // Stored protection, lock and quad bits
  always_ff @(posedge clk) begin
    if (!nv_rst_n) begin
      bp_reg <= {3{`FSP_FACTORY}};
      tb_reg <= `FSP_FACTORY;
      sec_reg <= `FSP_FACTORY;
      lm_reg <= {2{`FSP_FACTORY}};
      qe_reg <= `FSP_FACTORY;
      lb_reg <= {3{`FSP_FACTORY}};
      cmp_reg <= `FSP_FACTORY;
    end else if (!rst_n) begin
      if (lm_reg == 2'b10)
        lm_reg <= 2'b00;
    end else if (start && st_go) begin
      bp_reg <= d1_reg[`FSP_SL_BP +: 3];
      tb_reg <= d1_reg[`FSP_SL_TB];
      sec_reg <= d1_reg[`FSP_SL_SEC];
      lm_reg[0] <= d1_reg[`FSP_SL_LMLO];
      if (byte_reg >= 3'h3) begin
        lm_reg[1] <= d2_reg[`FSP_SH_LMHI];
        qe_reg <= d2_reg[`FSP_SH_QE];
        cmp_reg <= d2_reg[`FSP_SH_CMP];
        lb_reg <= lb_reg | d2_reg[`FSP_SH_LB +: 3];
      end
    end
  end

  // Pins and status outputs straight from flops
  assign so = so_reg;
  assign so_oe = so_oe_reg;
  assign busy = busy_reg;
  assign quad_mode = qe_reg;
  assign otp_lock = lb_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n || !nv_rst_n);

  a_busy_on_start: assert property (start |=> busy_reg[*2])
    else $error("busy not raised on accepted write");
  a_busy_ignore: assert property (
    cmd_end && busy_reg && op_reg == `FSP_OP_WREN |=> $stable(wel_reg))
    else $error("write enable taken while busy");
  a_busy_done: assert property (
    busy_reg && tmr_reg == 32'h1 && !cmd_end |=> !busy_reg && idle)
    else $error("busy did not clear at end");
  a_wel_set: assert property (
    cmd_end && !busy_reg && op_reg == `FSP_OP_WREN |=> wel_reg)
    else $error("latch not set by write enable");
  a_wel_clear: assert property (start |=> !wel_reg)
    else $error("latch not cleared by write");
  a_hw_lock: assert property (
    cmd_end && idle && lm_reg == 2'b01 && !wp_n && !qe_reg &&
    op_reg == `FSP_OP_WRSR
    |=> !busy_reg && $stable(bp_reg))
    else $error("status written with pin low");
  a_mode_lock: assert property (
    cmd_end && idle && lm_reg[1] && op_reg == `FSP_OP_WRSR
    |=> !busy_reg ##1 $stable(lm_reg))
    else $error("status written while locked");
  a_otp_sticky: assert property (
    (lb_reg & $past(lb_reg)) == $past(lb_reg))
    else $error("one-time lock bit cleared");
  a_susp_flag: assert property (
    cmd_end && busy_reg && !run_sr_reg && op_reg == `FSP_OP_SUSP
    |=> sus_reg && !busy_reg)
    else $error("suspend not taken");
  a_prot_ignore: assert property (
    cmd_end && idle && hit && op_reg == `FSP_OP_SE |=> !busy_reg)
    else $error("protected erase started");
  a_decode_top: assert property (
    !cmp_reg && !sec_reg && !tb_reg && bp_reg == 3'h1
    |-> pif.lo == 20'hf0000 && !pif.none)
    else $error("top sixteenth decoded wrong");

  c_status_write: cover property (start && st_go);
  c_suspend: cover property (sus_reg ##1 !sus_reg);
  c_prot_refuse: cover property (cmd_end && idle && hit && wel_reg);
  c_status_read: cover property (so_oe_reg && busy_reg);
endmodule : fsp_status_regs
`default_nettype wire
